/* File: src/usfd_pkg.sv */
// usfd_pkg: constants and carrier types for the fifo-backed serial transceiver
// assumes a single 50 MHz system clock shared by all users of the package
package usfd_pkg;
    localparam int CLK_HZ = 50000000;
    localparam int MAX_BAUD_BPS = 3000000;
    localparam int OVERSAMPLE = 16;
    // smallest divider that keeps the line rate at or below the top line rate with 16x sampling
    localparam int MIN_DIV = (CLK_HZ + MAX_BAUD_BPS * OVERSAMPLE - 1) / (MAX_BAUD_BPS * OVERSAMPLE);
    localparam int DIV_W = 16;
    localparam int FIFO_DEPTH = 16;
    localparam int PTR_W = 4;
    localparam int CNT_W = 5;
    localparam int DATA_W = 8;
    localparam logic [3:0] OS_MID = 4'h7;
    localparam logic [3:0] OS_LAST = 4'hF;

    // parity mode codes
    localparam logic [1:0] PAR_NONE = 2'h0;
    localparam logic [1:0] PAR_ODD = 2'h1;
    localparam logic [1:0] PAR_EVEN = 2'h2;
    localparam logic [1:0] PAR_STICK = 2'h3;

    // word length codes: data bits = 5 + code
    localparam logic [1:0] WLEN_5 = 2'h0;
    localparam logic [1:0] WLEN_8 = 2'h3;

    // threshold codes
    localparam logic [2:0] LVL_1_8 = 3'h0;
    localparam logic [2:0] LVL_1_4 = 3'h1;
    localparam logic [2:0] LVL_1_2 = 3'h2;
    localparam logic [2:0] LVL_3_4 = 3'h3;
    localparam logic [2:0] LVL_7_8 = 3'h4;

    typedef struct packed {
        logic [15:0] divisor;
        logic [1:0] word_len;
        logic [1:0] parity;
        logic stick_value;
        logic two_stop;
        logic send_break;
        logic fifo_en;
        logic flow_en;
        logic [2:0] tx_level;
        logic [2:0] rx_level;
    } usfd_cfg_t;

    typedef struct packed {
        logic parity_err;
        logic frame_err;
        logic break_err;
        logic overrun_err;
    } usfd_err_t;

    typedef struct packed {
        logic tx_single;
        logic tx_burst;
        logic rx_single;
        logic rx_burst;
    } usfd_dma_t;

    // threshold in entries for a level code, scaled to the active depth
    function automatic logic [4:0] usfd_level(input logic [2:0] code, input logic fifo_en);
        logic [4:0] lvl;
        lvl = 5'h02;
        case (code)
            LVL_1_8: lvl = 5'h02;
            LVL_1_4: lvl = 5'h04;
            LVL_1_2: lvl = 5'h08;
            LVL_3_4: lvl = 5'h0C;
            LVL_7_8: lvl = 5'h0E;
            default: lvl = 5'h08;
        endcase
        // one-entry mode: every level collapses to one entry
        return fifo_en ? lvl : 5'h01;
    endfunction : usfd_level
endpackage : usfd_pkg

/* File: src/usfd_fifo.sv */
// usfd_fifo: 16 x 8 flip-flop fifo with a programmable usable depth
// assumes nothing of the caller; a push when full or a pop when empty is ignored
module usfd_fifo (
    // clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // control
    input wire logic one_deep_in,
    input wire logic flush_in,
    // write side
    input wire logic push_in,
    input wire logic [7:0] wdata_in,
    // read side
    input wire logic pop_in,
    output logic [7:0] rdata_out,
    // status
    output logic [4:0] count_out,
    output logic full_out,
    output logic empty_out
);
    logic [7:0] mem [usfd_pkg::FIFO_DEPTH];
    logic [3:0] wptr;
    logic [3:0] rptr;
    logic [4:0] count;

    always_ff @(posedge clk_in) begin
        if (push_in && !full_out) begin
            mem[wptr] <= wdata_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in || flush_in) begin
            wptr <= 4'h0;
            rptr <= 4'h0;
            count <= 5'h00;
        end else begin
            if (push_in && !full_out) begin
                wptr <= wptr + 4'h1;
            end
            if (pop_in && !empty_out) begin
                rptr <= rptr + 4'h1;
            end
            count <= count + 5'((push_in && !full_out) ? 1 : 0) - 5'((pop_in && !empty_out) ? 1 : 0);
        end
    end

    assign rdata_out = mem[rptr];
    assign count_out = count;
    assign empty_out = (count == 5'h00);
    // usable depth is one entry in one-deep mode
    assign full_out = one_deep_in ? (count != 5'h00) : (count == 5'h10);
endmodule : usfd_fifo

/* File: src/usfd_uart.sv */
// usfd_uart: one serial transceiver channel with tx/rx fifos, baud divider,
// flow control, level and end-of-transmission events and dma requests
// assumes: cfg stable while the line is busy; dma/cpu pop and push as strobes
// Function
// - two instances each, own config and fifos
// - baud from system clock via divider
// - separate sixteen by eight tx, rx fifos
// - depth programmable, one-byte mode supported
// - thresholds one eighth to seven eighths
// - five to eight data bits per frame
// - even, odd, stick or no parity
// - one or two stop bits sent
// - send break, detect received break
// - pause on cts low, rts shows room
// - level and end-of-transmission events raised
// - separate tx and rx dma channels
// - rx single on data, burst at level
// - tx single on space, burst at level
module usfd_uart (
    // clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // configuration
    input wire usfd_pkg::usfd_cfg_t cfg_in,
    input wire logic flush_in,
    // transmit data
    input wire logic tx_push_in,
    input wire logic [7:0] tx_data_in,
    output logic tx_full_out,
    // receive data
    input wire logic rx_pop_in,
    output logic [7:0] rx_data_out,
    output logic rx_valid_out,
    output usfd_pkg::usfd_err_t rx_err_out,
    // serial pins
    output logic txd_out,
    input wire logic rxd_in,
    input wire logic cts_in,
    output logic rts_out,
    // events and dma
    output logic tx_level_evt_out,
    output logic rx_level_evt_out,
    output logic tx_done_evt_out,
    output usfd_pkg::usfd_dma_t dma_out
);
    // instancing this module twice gives the two channels
    typedef enum logic [4:0] {
        TX_IDLE = 5'b00001,
        TX_START = 5'b00010,
        TX_DATA = 5'b00100,
        TX_PAR = 5'b01000,
        TX_STOP = 5'b10000
    } usfd_txs_t;
    typedef enum logic [4:0] {
        RX_IDLE = 5'b00001,
        RX_START = 5'b00010,
        RX_DATA = 5'b00100,
        RX_PAR = 5'b01000,
        RX_STOP = 5'b10000
    } usfd_rxs_t;

    logic [15:0] div_cnt;
    logic [4:0] tx_cnt, rx_cnt, tx_lvl, rx_lvl;
    logic [7:0] tx_head, rx_word, tx_shift, rx_shift;
    logic [3:0] tx_os, rx_os;
    logic [2:0] nbits_m1, tx_bit, rx_bit;
    usfd_txs_t tx_state;
    usfd_rxs_t rx_state;
    logic tick, tx_empty, tx_pop, rx_full, rx_empty, rx_push;
    logic tx_par, tx_stop2, tx_line, rx_par, rx_line_d, all_zero;
    logic tx_above, rx_above, tx_busy_d;

    function automatic logic par_bit(input logic [1:0] mode, input logic stick, input logic xsum);
        return (mode == usfd_pkg::PAR_STICK) ? stick : ((mode == usfd_pkg::PAR_ODD) ? ~xsum : xsum);
    endfunction : par_bit

    assign nbits_m1 = 3'(cfg_in.word_len) + 3'h4;
    assign tx_lvl = usfd_pkg::usfd_level(cfg_in.tx_level, cfg_in.fifo_en);
    assign rx_lvl = usfd_pkg::usfd_level(cfg_in.rx_level, cfg_in.fifo_en);

    // divider at 16x line rate; a divisor below the minimum is clamped
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            div_cnt <= 16'h0000;
            tick <= 1'b0;
        end else if (div_cnt == 16'h0000) begin
            div_cnt <= (cfg_in.divisor < 16'(usfd_pkg::MIN_DIV)) ? 16'(usfd_pkg::MIN_DIV - 1)
                     : cfg_in.divisor - 16'h0001;
            tick <= 1'b1;
        end else begin
            div_cnt <= div_cnt - 16'h0001;
            tick <= 1'b0;
        end
    end

    usfd_fifo u_tx_fifo (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .one_deep_in(!cfg_in.fifo_en),
        .flush_in(flush_in),
        .push_in(tx_push_in),
        .wdata_in(tx_data_in),
        .pop_in(tx_pop),
        .rdata_out(tx_head),
        .count_out(tx_cnt),
        .full_out(tx_full_out),
        .empty_out(tx_empty)
    );

    usfd_fifo u_rx_fifo (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .one_deep_in(!cfg_in.fifo_en),
        .flush_in(flush_in),
        .push_in(rx_push),
        .wdata_in(rx_word),
        .pop_in(rx_pop_in),
        .rdata_out(rx_data_out),
        .count_out(rx_cnt),
        .full_out(rx_full),
        .empty_out(rx_empty)
    );

    // a new character starts only while cts is high, so a frame in flight completes
    assign tx_pop = tick && (tx_state == TX_IDLE) && !tx_empty && !cfg_in.send_break
                    && (!cfg_in.flow_en || cts_in);

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            tx_state <= TX_IDLE;
            tx_os <= 4'h0;
            tx_bit <= 3'h0;
            tx_shift <= 8'h00;
            tx_par <= 1'b0;
            tx_stop2 <= 1'b0;
            tx_line <= 1'b1;
        end else if (tick) begin
            tx_os <= tx_os + 4'h1;
            case (tx_state)
                TX_IDLE: begin
                    tx_os <= 4'h0;
                    tx_line <= 1'b1;
                    if (tx_pop) begin
                        tx_shift <= tx_head;
                        tx_par <= par_bit(cfg_in.parity, cfg_in.stick_value,
                            ^(tx_head & (8'hFF >> (3'h7 - nbits_m1))));
                        tx_line <= 1'b0;
                        tx_state <= TX_START;
                    end
                end
                TX_START: begin
                    if (tx_os == usfd_pkg::OS_LAST) begin
                        tx_line <= tx_shift[0];
                        tx_bit <= 3'h0;
                        tx_state <= TX_DATA;
                    end
                end
                TX_DATA: begin
                    if (tx_os == usfd_pkg::OS_LAST) begin
                        if (tx_bit == nbits_m1) begin
                            tx_stop2 <= 1'b0;
                            tx_line <= (cfg_in.parity == usfd_pkg::PAR_NONE) ? 1'b1 : tx_par;
                            tx_state <= (cfg_in.parity == usfd_pkg::PAR_NONE) ? TX_STOP : TX_PAR;
                        end else begin
                            tx_line <= tx_shift[tx_bit + 3'h1];
                            tx_bit <= tx_bit + 3'h1;
                        end
                    end
                end
                TX_PAR: begin
                    if (tx_os == usfd_pkg::OS_LAST) begin
                        tx_line <= 1'b1;
                        tx_state <= TX_STOP;
                    end
                end
                TX_STOP: begin
                    if (tx_os == usfd_pkg::OS_LAST) begin
                        if (cfg_in.two_stop && !tx_stop2) begin
                            tx_stop2 <= 1'b1;
                        end else begin
                            tx_state <= TX_IDLE;
                        end
                    end
                end
                default: tx_state <= TX_IDLE;
            endcase
        end
    end

    // break forces the line low once the current frame is out
    assign txd_out = tx_line && !(cfg_in.send_break && tx_state == TX_IDLE);
    assign rts_out = !rx_full;

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            rx_state <= RX_IDLE;
            rx_os <= 4'h0;
            rx_bit <= 3'h0;
            rx_shift <= 8'h00;
            rx_par <= 1'b0;
            all_zero <= 1'b0;
            rx_line_d <= 1'b1;
        end else if (tick) begin
            rx_line_d <= rxd_in;
            rx_os <= rx_os + 4'h1;
            case (rx_state)
                RX_IDLE: begin
                    rx_os <= 4'h0;
                    if (rx_line_d && !rxd_in) begin
                        rx_state <= RX_START;
                    end
                end
                RX_START: begin
                    if (rx_os == usfd_pkg::OS_MID) begin
                        // a glitch shorter than half a bit is rejected here
                        rx_state <= rxd_in ? RX_IDLE : RX_DATA;
                        rx_os <= 4'h0;
                        rx_bit <= 3'h0;
                        rx_shift <= 8'h00;
                        all_zero <= 1'b1;
                    end
                end
                RX_DATA: begin
                    if (rx_os == usfd_pkg::OS_LAST) begin
                        rx_shift[rx_bit] <= rxd_in;
                        all_zero <= all_zero && !rxd_in;
                        rx_bit <= rx_bit + 3'h1;
                        if (rx_bit == nbits_m1) begin
                            rx_state <= (cfg_in.parity == usfd_pkg::PAR_NONE) ? RX_STOP : RX_PAR;
                        end
                    end
                end
                RX_PAR: begin
                    if (rx_os == usfd_pkg::OS_LAST) begin
                        rx_par <= rxd_in;
                        all_zero <= all_zero && !rxd_in;
                        rx_state <= RX_STOP;
                    end
                end
                RX_STOP: begin
                    if (rx_os == usfd_pkg::OS_LAST) begin
                        all_zero <= all_zero && !rxd_in;
                        rx_state <= RX_IDLE;
                    end
                end
                default: rx_state <= RX_IDLE;
            endcase
        end
    end

    assign rx_word = rx_shift;
    assign rx_push = tick && (rx_state == RX_STOP) && (rx_os == usfd_pkg::OS_LAST);

    // error flags track the most recent character; overrun is sticky until flush
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            rx_err_out <= '0;
        end else begin
            if (rx_push) begin
                rx_err_out.frame_err <= !rxd_in;
                rx_err_out.break_err <= all_zero && !rxd_in;
                rx_err_out.parity_err <= (cfg_in.parity != usfd_pkg::PAR_NONE)
                    && (rx_par != par_bit(cfg_in.parity, cfg_in.stick_value, ^rx_shift));
            end
            if (rx_push && rx_full) begin
                rx_err_out.overrun_err <= 1'b1;
            end else if (flush_in) begin
                rx_err_out.overrun_err <= 1'b0;
            end
        end
    end

    assign rx_valid_out = !rx_empty;

    // tx level: at or below threshold; rx level: at or above threshold
    assign tx_above = (tx_cnt > tx_lvl);
    assign rx_above = (rx_cnt >= rx_lvl);

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            dma_out <= '0;
            tx_level_evt_out <= 1'b0;
            rx_level_evt_out <= 1'b0;
            tx_done_evt_out <= 1'b0;
            tx_busy_d <= 1'b0;
        end else begin
            dma_out.tx_single <= !tx_full_out && !(tx_push_in);
            dma_out.tx_burst <= !tx_above && !tx_push_in;
            dma_out.rx_single <= !rx_empty && !rx_pop_in;
            dma_out.rx_burst <= rx_above && !rx_pop_in;
            tx_level_evt_out <= tx_above && (tx_cnt - 5'h01 == tx_lvl) && tx_pop;
            rx_level_evt_out <= rx_push && (rx_cnt + 5'h01 == rx_lvl);
            tx_busy_d <= (tx_state != TX_IDLE) || !tx_empty;
            tx_done_evt_out <= tx_busy_d && (tx_state == TX_IDLE) && tx_empty;
        end
    end

    a_cts_pause: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (cfg_in.flow_en && !cts_in && tx_state == TX_IDLE) |=> (tx_state == TX_IDLE))
        else $error("character started while cts low");
    a_rts_room: assert property (@(posedge clk_in) disable iff (!rstn_in)
        rts_out == (rx_cnt < (cfg_in.fifo_en ? 5'(usfd_pkg::FIFO_DEPTH) : 5'h01)))
        else $error("rts does not track receive room");
    a_idle_high: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (tx_state == TX_IDLE && !cfg_in.send_break && !$past(tx_pop)) |-> txd_out)
        else $error("idle line not high");
    a_start_low: assert property (@(posedge clk_in) disable iff (!rstn_in)
        tx_pop |=> (tx_state == TX_START && !txd_out))
        else $error("start bit not low");
    a_break_low: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (cfg_in.send_break && tx_state == TX_IDLE) |-> (!txd_out && !tx_pop))
        else $error("break not driven");
    a_rx_single: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (rx_cnt != 5'h00 && !rx_pop_in) |=> dma_out.rx_single)
        else $error("rx single request missing");
    a_tx_single: assert property (@(posedge clk_in) disable iff (!rstn_in)
        $rose(tx_full_out) |=> !dma_out.tx_single)
        else $error("tx single request while full");
    a_one_deep: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (!cfg_in.fifo_en && tx_cnt != 5'h00) |-> tx_full_out)
        else $error("one-deep mode accepts second byte");
    a_div_tick: assert property (@(posedge clk_in) disable iff (!rstn_in)
        tick |=> !tick)
        else $error("divider ticks back to back");
    a_rx_burst: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (rx_cnt >= rx_lvl && !rx_pop_in) |=> dma_out.rx_burst)
        else $error("rx burst request missing");
    c_tx_frame: cover property (@(posedge clk_in) disable iff (!rstn_in) tx_done_evt_out);
    c_rx_char: cover property (@(posedge clk_in) disable iff (!rstn_in) rx_push);
    c_rx_burst: cover property (@(posedge clk_in) disable iff (!rstn_in) dma_out.rx_burst);
    c_overrun: cover property (@(posedge clk_in) disable iff (!rstn_in) rx_err_out.overrun_err);
endmodule : usfd_uart

/* File: tb/usfd_peer.sv */
// usfd_peer: remote serial peer, captures frames on txd and sends frames on rxd
// assumes the bench keeps bit_clks at 16 times the divisor and len_in at bits after start
module usfd_peer (
    // clock
    input wire logic clk_in,
    // serial pins
    input wire logic txd_in,
    input wire logic rts_in,
    output logic rxd_out,
    output logic cts_out,
    // frame length
    input wire logic [3:0] len_in
);
    timeunit 1ns;
    timeprecision 1ns;
    int bit_clks = 32;
    // counts sends that gave up waiting for rts
    int n_late = 0;
    logic [11:0] got[$];
    logic [11:0] sh;
    initial begin
        rxd_out = 1'b1;
        cts_out = 1'b1;
    end
    // mid-bit sampling; unused high bits stay zero
    always begin
        @(negedge txd_in);
        sh = '0;
        repeat (bit_clks / 2) @(posedge clk_in);
        for (int i = 0; i < len_in; i++) begin
            repeat (bit_clks) @(posedge clk_in);
            sh[i] = txd_in;
        end
        got.push_back(sh);
    end
    // holds off while rts is low, unless the bench overruns on purpose
    task automatic send(input logic [11:0] b, input logic over);
        for (int k = 0; k < 5000 && !rts_in && !over; k++) @(negedge clk_in);
        if (!rts_in && !over) n_late++;
        rxd_out = 1'b0;
        repeat (bit_clks) @(negedge clk_in);
        for (int i = 0; i < len_in; i++) begin
            rxd_out = b[i];
            repeat (bit_clks) @(negedge clk_in);
        end
        rxd_out = 1'b1;
    endtask : send
endmodule : usfd_peer

/* File: tb/usfd_uart_tb.sv */
// usfd_uart_tb: random and corner-case bench for one transceiver channel
// assumes usfd_peer on the serial pins; divisor 2 keeps a bit at 32 clocks
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("mismatch %s exp %h got %h", nm, e, g); end end
module usfd_uart_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_in = 1'b0;
    logic rstn_in = 1'b0;
    usfd_pkg::usfd_cfg_t cfg = '0;
    logic flush = 1'b0;
    logic push = 1'b0;
    logic pop = 1'b0;
    logic [7:0] tdat = 8'h00;
    logic [7:0] rdat;
    logic tx_full, rx_valid, txd, rxd, cts, rts, tx_lvl, rx_lvl, tx_done;
    logic [3:0] len = 4'h9;
    usfd_pkg::usfd_err_t err;
    usfd_pkg::usfd_dma_t dma;
    int n_errors = 0;
    int num_checks = 0;
    int n_done = 0;
    int n_rxlvl = 0;
    int n_txlvl = 0;

    always #10 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        n_done <= n_done + int'(tx_done);
        n_txlvl <= n_txlvl + int'(tx_lvl);
        n_rxlvl <= n_rxlvl + int'(rx_lvl);
    end

    usfd_uart dut (.clk_in(clk_in), .rstn_in(rstn_in), .cfg_in(cfg), .flush_in(flush),
        .tx_push_in(push), .tx_data_in(tdat), .tx_full_out(tx_full), .rx_pop_in(pop),
        .rx_data_out(rdat), .rx_valid_out(rx_valid), .rx_err_out(err), .txd_out(txd),
        .rxd_in(rxd), .cts_in(cts), .rts_out(rts), .tx_level_evt_out(tx_lvl),
        .rx_level_evt_out(rx_lvl), .tx_done_evt_out(tx_done), .dma_out(dma));
    usfd_peer peer (.clk_in(clk_in), .txd_in(txd), .rts_in(rts), .rxd_out(rxd),
        .cts_out(cts), .len_in(len));

    function automatic int nb(input usfd_pkg::usfd_cfg_t c);
        return 6 + c.word_len + (c.parity != usfd_pkg::PAR_NONE) + c.two_stop;
    endfunction : nb
    function automatic logic [7:0] msk(input usfd_pkg::usfd_cfg_t c);
        return 8'hFF >> (3 - c.word_len);
    endfunction : msk
    // bits after the start bit, lsb first, zero beyond the frame
    function automatic logic [11:0] frame(input usfd_pkg::usfd_cfg_t c, input logic [7:0] d);
        logic [11:0] f;
        int w;
        w = 5 + c.word_len;
        d = d & msk(c);
        f = 12'hFFF;
        for (int i = 0; i < w; i++) f[i] = d[i];
        if (c.parity == usfd_pkg::PAR_ODD) f[w] = ~^d;
        if (c.parity == usfd_pkg::PAR_EVEN) f[w] = ^d;
        if (c.parity == usfd_pkg::PAR_STICK) f[w] = c.stick_value;
        return f & ((12'h001 << nb(c)) - 12'h001);
    endfunction : frame

    task automatic tick(input int n);
        repeat (n) @(negedge clk_in);
    endtask : tick
    // a spare cycle after each strobe keeps two strobes from sharing a time step
    task automatic put(input logic [7:0] d);
        tdat = d;
        push = 1'b1;
        tick(1);
        push = 1'b0;
        tick(1);
    endtask : put
    task automatic take();
        pop = 1'b1;
        tick(1);
        pop = 1'b0;
        tick(1);
    endtask : take
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : complete_run
    task automatic wait_for(input logic rx);
        int k;
        for (k = 0; k < 3000; k++) begin
            if (rx ? rx_valid === 1'b1 : peer.got.size() > 0) break;
            tick(1);
        end
        if (k == 3000) begin
            n_errors++;
            $display("timeout waiting for %s", rx ? "rx data" : "tx frame");
            complete_run();
        end
    endtask : wait_for

    initial begin
        logic [7:0] d;
        logic [11:0] f;
        logic bad;
        int base;
        void'($urandom(32'h3b69_ae26));
        cfg.divisor = 16'h0002;
        cfg.fifo_en = 1'b1;
        cfg.flow_en = 1'b1;
        tick(10);
        `CHK("txd reset", 1'b1, txd)
        `CHK("rts reset", 1'b1, rts)
        `CHK("dma reset", 4'h0, dma)
        rstn_in = 1'b1;
        tick(3);
        `CHK("tx single", 1'b1, dma.tx_single)
        `CHK("rx single", 1'b0, dma.rx_single)
        for (int m = 0; m < 16; m++) begin
            cfg.word_len = m[1:0];
            cfg.parity = m[3:2];
            cfg.two_stop = 1'($urandom);
            cfg.stick_value = 1'($urandom);
            len = 4'(nb(cfg));
            d = 8'($urandom);
            peer.got.delete();
            base = n_done;
            put(d);
            wait_for(1'b0);
            `CHK("tx frame", frame(cfg, d), peer.got[0])
            tick(40);
            `CHK("tx done", 1, n_done - base)
            // odd passes that use parity corrupt the parity bit
            d = 8'($urandom);
            f = frame(cfg, d);
            bad = m[0] && cfg.parity != usfd_pkg::PAR_NONE;
            if (bad) f[5 + cfg.word_len] = ~f[5 + cfg.word_len];
            peer.send(f, 1'b0);
            wait_for(1'b1);
            tick(2);
            `CHK("rx data", d & msk(cfg), rdat)
            `CHK("parity flag", bad, err.parity_err)
            `CHK("frame flag", 1'b0, err.frame_err)
            `CHK("rx single", 1'b1, dma.rx_single)
            take();
            `CHK("rx empty", 1'b0, rx_valid)
        end
        cfg.tx_level = usfd_pkg::LVL_7_8;
        peer.cts_out = 1'b0;
        for (int i = 0; i < 17; i++) put(8'(i));
        tick(64);
        `CHK("cts hold", 1'b1, txd)
        `CHK("tx full", 1'b1, tx_full)
        `CHK("no space", 1'b0, dma.tx_single)
        `CHK("tx burst", 1'b0, dma.tx_burst)
        // two characters leave, the fifo falls from 16 to the 14-entry level
        base = n_txlvl;
        peer.cts_out = 1'b1;
        tick(450);
        peer.cts_out = 1'b0;
        tick(400);
        `CHK("tx level", 1, n_txlvl - base)
        `CHK("tx burst lvl", 1'b1, dma.tx_burst)
        flush = 1'b1;
        tick(1);
        flush = 1'b0;
        tick(2);
        `CHK("flushed", 1'b0, tx_full)
        `CHK("burst free", 1'b1, dma.tx_burst)
        cfg.fifo_en = 1'b0;
        put(8'hA5);
        `CHK("one deep", 1'b1, tx_full)
        peer.got.delete();
        peer.cts_out = 1'b1;
        wait_for(1'b0);
        `CHK("cts frame", frame(cfg, 8'hA5), peer.got[0])
        base = n_rxlvl;
        peer.send(frame(cfg, 8'h3C), 1'b0);
        tick(3);
        `CHK("rts full", 1'b0, rts)
        `CHK("rx burst", 1'b1, dma.rx_burst)
        `CHK("rx level", 1, n_rxlvl - base)
        peer.send(frame(cfg, 8'hC3), 1'b1);
        tick(3);
        `CHK("overrun", 1'b1, err.overrun_err)
        `CHK("kept byte", 8'h3C, rdat)
        take();
        `CHK("rts free", 1'b1, rts)
        peer.send(12'h000, 1'b0);
        tick(40);
        `CHK("break in", 1'b1, err.break_err)
        `CHK("break frame", 1'b1, err.frame_err)
        cfg.send_break = 1'b1;
        tick(100);
        `CHK("break out", 1'b0, txd)
        cfg.send_break = 1'b0;
        tick(40);
        `CHK("break end", 1'b1, txd)
        `CHK("peer wait", 0, peer.n_late)
        complete_run();
    end
endmodule : usfd_uart_tb
